// *** afe_regs_pkg.sv ***
// package for the front-end configuration and fault register slice
package afe_regs_pkg;
  // ==========================================================
  // register indices (byte address is four times the index)
  localparam logic [7:0] REF_AMP_IDX = 8'h03; // reference and amp config
  localparam logic [7:0] FAULT_CTRL_IDX = 8'h04; // threshold control
  localparam logic [7:0] CHAN_FIRST_IDX = 8'h05; // channel one settings
  localparam logic [7:0] CHAN_LAST_IDX = 8'h0C; // channel eight settings
  localparam logic [7:0] POS_FAULT_IDX = 8'h12; // positive fault status
  localparam logic [7:0] IRQ_STATUS_IDX = 8'h20; // sticky fault events
  localparam logic [7:0] IRQ_MASK_IDX = 8'h21; // interrupt mask
  // ==========================================================
  // reset values
  localparam logic [7:0] REF_AMP_RST = 8'hE0;
  localparam logic [7:0] FAULT_CTRL_RST = 8'h00;
  localparam logic [7:0] CHAN_RST = 8'h10;
  localparam logic [7:0] POS_FAULT_RST = 8'h00;
  // ==========================================================
  // field positions and fixed bits
  localparam int REF_HIGH_BIT = 5;
  localparam int AMP_SRC_BIT = 3;
  localparam int AMP_EN_BIT = 2;
  localparam logic [7:0] REF_AMP_ONES = 8'hC0; // bits 7-6 read high
  localparam logic [7:0] REF_AMP_WMASK = 8'h2C; // only 5,3,2 store
  localparam logic [7:0] FAULT_CTRL_WMASK = 8'hE0;
  localparam logic [7:0] CHAN_WMASK = 8'hF7;
  localparam int NUM_CHANNELS = 8;
  localparam int APB_ADDR_W = 12;
  // gain and input codes
  typedef enum logic [2:0] {
    GAIN_1 = 3'h1, GAIN_2 = 3'h2, GAIN_4 = 3'h4, GAIN_8 = 3'h5, GAIN_12 = 3'h6
  } gain_code_t;
  typedef enum logic [2:0] {
    IN_NORMAL = 3'h0, IN_MID_SHORT = 3'h1, IN_SUPPLY = 3'h3,
    IN_TEMP = 3'h4, IN_TEST = 3'h5
  } input_sel_t;
  // ==========================================================
  // carriers
  typedef struct packed {
    logic channelPowerDown;
    logic [2:0] amplifierGainCode;
    logic [2:0] channelInputSelect;
  } chan_ctrl_t;
  typedef struct packed {
    logic referenceHighSelect;
    logic ampNoninvSource;
    logic ampPowerEnable;
    logic [2:0] comparatorThresholdCode;
  } analog_ctrl_t;
  typedef struct packed {
    logic [APB_ADDR_W-1:0] paddr;
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] pwdata;
  } apb_req_t;
endpackage

// *** afe_channel_fault_config_regs.sv ***
// apb register slice: reference, fault threshold, channel settings, fault status
//
// How it works
// RULE_01: reference select bit, resets set
// RULE_02: bit 3 picks amp noninverting source
// RULE_03: bit 2 enables op amp, reset clear
// RULE_04: bits 7-6 always read high
// RULE_05: bit 1 always reads zero
// RULE_06: bit 0 read-only, ignores writes
// RULE_07: other reserved bits read low
// RULE_08: threshold code picks high-side level
// RULE_09: same code picks mirrored low-side level
// RULE_10: fault control at 04h, resets zero
// RULE_11: eight channel registers at 05h-0Ch
// RULE_12: channel registers reset to 10h
// RULE_13: bit 7 powers channel down
// RULE_14: gain code field bits 6-4
// RULE_15: input select field bits 2-0
// RULE_16: status at 12h, read-only, resets zero
// RULE_17: flag follows comparator over threshold
//
// Local design decision: register access over APB.
`timescale 1ns/1ps
`default_nettype none
module afe_channel_fault_config_regs #(
  parameter int CHANNELS = 8
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire afe_regs_pkg::apb_req_t apbReq,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  input wire logic [CHANNELS-1:0] positiveInputOverThreshold,
  output afe_regs_pkg::analog_ctrl_t analogCtrl,
  output afe_regs_pkg::chan_ctrl_t [CHANNELS-1:0] chanCtrl,
  output logic faultIrq
);
  import afe_regs_pkg::*;

  // ==========================================================
  // bus decode
  wire logic setupPhase = apbReq.psel && !apbReq.penable;
  wire logic accessPhase = apbReq.psel && apbReq.penable;
  wire logic [APB_ADDR_W-3:0] wordIdx = apbReq.paddr[APB_ADDR_W-1:2];
  wire logic wrStrobe = accessPhase && apbReq.pwrite;
  wire logic [7:0] wrByte = apbReq.pwdata[7:0];
  wire logic hitRefAmp = (wordIdx == 10'(REF_AMP_IDX));
  wire logic hitFaultCtrl = (wordIdx == 10'(FAULT_CTRL_IDX)); // see RULE_10
  wire logic hitChan = (wordIdx >= 10'(CHAN_FIRST_IDX)) &&
                       (wordIdx <= 10'(CHAN_LAST_IDX)); // see RULE_11
  wire logic hitPosFault = (wordIdx == 10'(POS_FAULT_IDX)); // see RULE_16
  wire logic hitIrqStat = (wordIdx == 10'(IRQ_STATUS_IDX));
  wire logic hitIrqMask = (wordIdx == 10'(IRQ_MASK_IDX));
  wire logic hitAny = hitRefAmp || hitFaultCtrl || hitChan || hitPosFault ||
                      hitIrqStat || hitIrqMask;
  // channel one sits at the lowest offset
  wire logic [2:0] chanSel = 3'(wordIdx - 10'(CHAN_FIRST_IDX)); // see RULE_11

  // zero wait states: the slave answers in the first access cycle
  assign pready = accessPhase;
  assign pslverr = 1'b0;

  // ==========================================================
  // storage
  logic [7:0] refAmp_q; // only the writable bits ever change
  logic [7:0] faultCtrl_q;
  logic [7:0] chanSet_q [CHANNELS];
  logic [7:0] posFault_q;
  logic [7:0] irqStat_q;
  logic [7:0] irqMask_q;
  logic [7:0] posFaultPrev_q; // for rising-edge events
  logic [31:0] prdata_q;

  // reference/amp register: reserved bits are forced on read, not stored
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      refAmp_q <= REF_AMP_RST & REF_AMP_WMASK; // see RULE_01
    end else if (wrStrobe && hitRefAmp) begin
      refAmp_q <= wrByte & REF_AMP_WMASK; // see RULE_06
    end
  end

  // threshold control keeps only its code field
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      faultCtrl_q <= FAULT_CTRL_RST; // see RULE_10
    end else if (wrStrobe && hitFaultCtrl) begin
      faultCtrl_q <= wrByte & FAULT_CTRL_WMASK; // see RULE_07
    end
  end

  // channel settings, bit 3 never stored
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int i = 0; i < CHANNELS; i++) begin
        chanSet_q[i] <= CHAN_RST; // see RULE_12
      end
    end else if (wrStrobe && hitChan) begin
      chanSet_q[chanSel] <= wrByte & CHAN_WMASK; // see RULE_07
    end
  end

  // ==========================================================
  // fault status: the comparator outputs already reflect the threshold chosen
  // by the code field, so the flag simply tracks them each cycle
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      posFault_q <= POS_FAULT_RST;
      posFaultPrev_q <= POS_FAULT_RST;
    end else begin
      posFault_q <= 8'(positiveInputOverThreshold); // see RULE_17
      posFaultPrev_q <= posFault_q;
    end
  end

  // ==========================================================
  // interrupts: new fault sets sticky bit, write one clears, set wins
  wire logic [7:0] faultRise = posFault_q & ~posFaultPrev_q;
  wire logic [7:0] irqClear = (wrStrobe && hitIrqStat) ? wrByte : 8'h00;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      irqStat_q <= 8'h00;
      irqMask_q <= 8'h00;
    end else begin
      irqStat_q <= (irqStat_q & ~irqClear) | faultRise;
      if (wrStrobe && hitIrqMask) begin
        irqMask_q <= wrByte;
      end
    end
  end
  assign faultIrq = |(irqStat_q & irqMask_q);

  // ==========================================================
  // read mux
  wire logic [7:0] refAmpRead = (refAmp_q & REF_AMP_WMASK) | REF_AMP_ONES; // see RULE_04
  wire logic [7:0] rdByte =
    hitRefAmp ? refAmpRead : // bits 4,1,0 read zero, see RULE_05
    hitFaultCtrl ? faultCtrl_q :
    hitChan ? chanSet_q[chanSel] :
    hitPosFault ? posFault_q : // see RULE_16
    hitIrqStat ? irqStat_q :
    hitIrqMask ? irqMask_q : 8'h00;

  // read data registered in setup so it is valid through the access cycle
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      prdata_q <= 32'h0000_0000;
    end else if (setupPhase && !apbReq.pwrite) begin
      prdata_q <= hitAny ? {24'h00_0000, rdByte} : 32'h0000_0000;
    end
  end
  assign prdata = prdata_q;

  // ==========================================================
  // analog controls
  assign analogCtrl.referenceHighSelect = refAmp_q[REF_HIGH_BIT]; // see RULE_01
  assign analogCtrl.ampNoninvSource = refAmp_q[AMP_SRC_BIT]; // see RULE_02
  assign analogCtrl.ampPowerEnable = refAmp_q[AMP_EN_BIT]; // see RULE_03
  // one code drives both high-side and low-side levels
  assign analogCtrl.comparatorThresholdCode = faultCtrl_q[7:5]; // see RULE_08 RULE_09
  for (genvar c = 0; c < CHANNELS; c++) begin : gChan
    assign chanCtrl[c].channelPowerDown = chanSet_q[c][7]; // see RULE_13
    assign chanCtrl[c].amplifierGainCode = chanSet_q[c][6:4]; // see RULE_14
    assign chanCtrl[c].channelInputSelect = chanSet_q[c][2:0]; // see RULE_15
  end

  // ==========================================================
  // checks
  a_refamp_fixed_bits: assert property (@(posedge clk) disable iff (sys_rst)
    (refAmp_q & 8'hD3) == 8'h00) else $error("reserved ref bits stored"); // see RULE_06
  a_refamp_read_ones: assert property (@(posedge clk) disable iff (sys_rst)
    refAmpRead[7:6] == 2'b11 && refAmpRead[4] == 1'b0 && refAmpRead[1] == 1'b0)
    else $error("ref reserved read wrong"); // see RULE_04
  a_chan_bit3_low: assert property (@(posedge clk) disable iff (sys_rst)
    chanSet_q[0][3] == 1'b0 && chanSet_q[CHANNELS-1][3] == 1'b0)
    else $error("channel bit 3 set"); // see RULE_07
  a_fault_low_bits: assert property (@(posedge clk) disable iff (sys_rst)
    faultCtrl_q[4:0] == 5'h00) else $error("fault ctrl low bits set"); // see RULE_07
  a_chan_write_lands: assert property (@(posedge clk) disable iff (sys_rst)
    wrStrobe && hitChan |=> chanSet_q[$past(chanSel)] == ($past(wrByte) & CHAN_WMASK))
    else $error("channel write lost"); // see RULE_11
  a_status_follows: assert property (@(posedge clk) disable iff (sys_rst)
    ##1 posFault_q == $past(8'(positiveInputOverThreshold)))
    else $error("status not tracking comparators"); // see RULE_17
  a_status_readonly: assert property (@(posedge clk) disable iff (sys_rst)
    setupPhase && !apbReq.pwrite && hitPosFault |=> prdata[7:0] == $past(posFault_q))
    else $error("status read wrong"); // see RULE_16
  a_thresh_code: assert property (@(posedge clk) disable iff (sys_rst)
    wrStrobe && hitFaultCtrl |=> analogCtrl.comparatorThresholdCode == $past(wrByte[7:5]))
    else $error("threshold code not applied"); // see RULE_08
  a_irq_set_wins: assert property (@(posedge clk) disable iff (sys_rst)
    |faultRise |=> (irqStat_q & $past(faultRise)) == $past(faultRise))
    else $error("fault event lost");
endmodule
`default_nettype wire

// *** afe_channel_fault_config_regs_tb.sv ***
// self-checking bench for the front-end configuration and fault register slice
`timescale 1ns/1ps
`default_nettype none
module afe_channel_fault_config_regs_tb;
  import afe_regs_pkg::*;
  // ==========================================================
  // signals and counters
  logic clk; // 200 MHz bench clock
  logic sys_rst; // async reset, active high
  apb_req_t apbReq; // request bundle driven by the bus tasks
  logic pready, pslverr;
  logic [31:0] prdata, rd;
  logic [7:0] posIn; // comparator levels, bit0 is channel one
  analog_ctrl_t analogCtrl;
  chan_ctrl_t [7:0] chanCtrl;
  logic faultIrq;
  int errTotal = 0, nCompared = 0, cycles = 0;
  // ordinary cases: address, value written, reset value, value read back
  typedef struct {logic [11:0] a; logic [7:0] w, r0, r1;} row_t;
  row_t rows [6] = '{'{12'h00C, 8'h1F, 8'hE0, 8'hCC}, '{12'h010, 8'hFF, 8'h00, 8'hE0},
    '{12'h014, 8'hFF, 8'h10, 8'hF7}, '{12'h030, 8'h5D, 8'h10, 8'h55},
    '{12'h048, 8'hFF, 8'h00, 8'h00}, '{12'h034, 8'hFF, 8'h00, 8'h00}};
  logic [2:0] gains [5] = '{3'h1, 3'h2, 3'h4, 3'h5, 3'h6};
  logic [2:0] sels [5] = '{3'h0, 3'h1, 3'h3, 3'h4, 3'h5};
  afe_channel_fault_config_regs #(.CHANNELS(8)) afe_channel_fault_config_regs_inst (
    .clk(clk), .sys_rst(sys_rst), .apbReq(apbReq), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .positiveInputOverThreshold(posIn), .analogCtrl(analogCtrl),
    .chanCtrl(chanCtrl), .faultIrq(faultIrq));
  // ==========================================================
  // clock and hang guard
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // a stuck handshake would otherwise run forever
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      errTotal++;
      endOfTest();
    end
  end
  // ==========================================================
  // tasks
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    nCompared++;
    if (seen !== exp) begin
      errTotal++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // one apb transfer: setup, access held until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
    @(posedge clk);
    apbReq.psel <= 1'b1;
    apbReq.penable <= 1'b0;
    apbReq.pwrite <= wr;
    apbReq.paddr <= a;
    apbReq.pwdata <= {24'h0, d};
    @(posedge clk);
    apbReq.penable <= 1'b1;
    // no wait count assumed here: only the hang guard ends a stuck wait
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    chk("slave error", 32'(pslverr), 32'h0); // error response never used
    apbReq.psel <= 1'b0;
    apbReq.penable <= 1'b0;
    #1;
  endtask
  task automatic endOfTest();
    $display("compared %0d mismatches %0d", nCompared, errTotal);
    if (errTotal == 0 && nCompared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // ==========================================================
  // main sequence
  initial begin
    sys_rst = 1'b1;
    apbReq = '0;
    posIn = 8'h00;
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    // reset value, write, readback for ref/amp, fault control, channels one and eight, status and an unmapped address
    foreach (rows[i]) begin
      apb(1'b0, rows[i].a, 8'h00);
      chk("reset value", rd, {24'h0, rows[i].r0});
      apb(1'b1, rows[i].a, rows[i].w);
      apb(1'b0, rows[i].a, 8'h00);
      chk("readback", rd, {24'h0, rows[i].r1});
    end
    chk("analog ctrl", 32'(analogCtrl), 32'h1F);
    chk("chan one", 32'(chanCtrl[0]), 32'h7F);
    chk("chan eight", 32'(chanCtrl[7]), 32'h2D);
    $display("table tests done");
    // every threshold code, and each legal gain and input code on channel two
    for (int i = 0; i < 8; i++) begin
      apb(1'b1, 12'h010, {3'(i), 5'h1F});
      chk("threshold code", 32'(analogCtrl.comparatorThresholdCode), i);
      if (i < 5) begin
        apb(1'b1, 12'h018, {1'b0, gains[i], 1'b0, sels[i]});
        chk("chan two", 32'(chanCtrl[1]), {25'h0, gains[i], sels[i]});
      end
    end
    $display("code tests done");
    // fault flags follow the comparators; sticky event bits drive the interrupt
    @(posedge clk);
    posIn <= 8'h81;
    repeat (3) @(posedge clk);
    apb(1'b0, 12'h048, 8'h00);
    chk("fault status", rd, 32'h81);
    chk("irq masked", 32'(faultIrq), 32'h0);
    apb(1'b1, 12'h084, 8'hFF);
    chk("irq unmasked", 32'(faultIrq), 32'h1);
    @(posedge clk);
    posIn <= 8'h00;
    repeat (3) @(posedge clk);
    apb(1'b1, 12'h080, 8'h01);
    apb(1'b0, 12'h080, 8'h00);
    chk("sticky events", rd, 32'h80);
    chk("irq still", 32'(faultIrq), 32'h1);
    apb(1'b1, 12'h084, 8'h00);
    chk("irq mask off", 32'(faultIrq), 32'h0);
    apb(1'b1, 12'h080, 8'h80);
    apb(1'b0, 12'h080, 8'h00);
    chk("events cleared", rd, 32'h0);
    apb(1'b0, 12'h048, 8'h00);
    chk("flags cleared", rd, 32'h0);
    $display("fault tests done");
    // a second reset in mid-run restores the defaults
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    apb(1'b0, 12'h00C, 8'h00);
    chk("ref amp after reset", rd, 32'hE0);
    apb(1'b0, 12'h014, 8'h00);
    chk("chan one after reset", rd, 32'h10);
    $display("reset test done");
    endOfTest();
  end
endmodule
`default_nettype wire
